/* rtl/rxpa_pkg.sv */
// Purpose: Shared constants for the receiver output timing and phase-align block
// Assumes: One 20 MHz clock (pclk), APB register access
// Notes: Word field sits in code[19:4] with w0 at bit 4; C-field c0..c3 in code[3:0]
package rxpa_pkg;
  // ************************************************************
  // Widths and register map
  // ************************************************************
  localparam int CODE_W = 20;
  localparam int DATA_W = 16;
  localparam int BND_W = DATA_W + 4;
  localparam int PH_W = 8;
  localparam int ADDR_W = 8;
  localparam logic [ADDR_W-1:0] ADDR_CTRL = 8'h00;
  localparam logic [ADDR_W-1:0] ADDR_STAT = 8'h04;
  localparam logic [ADDR_W-1:0] ADDR_PHASE = 8'h08;
  localparam int CTRL_MODE_BIT = 0;
  localparam logic CTRL_MODE_RST = 1'b0;
  localparam int STAT_READY_BIT = 0;
  localparam int STAT_NEED_BIT = 1;
  localparam int STAT_SRQ_BIT = 2;
  localparam int STAT_SLIP_BIT = 3;
  // ************************************************************
  // Line code fields
  // ************************************************************
  localparam int WF_LSB = 4;
  localparam int W7_POS = 11;
  localparam int W8_POS = 12;
  localparam logic [3:0] CF_DT0 = 4'hD;
  localparam logic [3:0] CF_DI0 = 4'h2;
  localparam logic [3:0] CF_DT1 = 4'hB;
  localparam logic [3:0] CF_DI1 = 4'h4;
  localparam logic [3:0] CF_CT = 4'h3;
  localparam logic [3:0] CF_CI = 4'hC;
  localparam logic [1:0] W78_CT = 2'h1;
  localparam logic [1:0] W78_CI = 2'h2;
  localparam logic [1:0] W78_IA = 2'h3;
  localparam logic [1:0] W78_IB = 2'h0;
  // ************************************************************
  // Rates, counts and pin synchroniser slots
  // ************************************************************
  localparam logic [1:0] RATE_FULL = 2'h0;
  localparam logic [1:0] RATE_HALF = 2'h1;
  localparam logic [1:0] RATE_QUARTER = 2'h2;
  localparam logic [1:0] RATE_TEST = 2'h3;
  localparam int BASE_DIV_DEF = 8;
  localparam int GOOD_MIN_DEF = 64;
  localparam int BAD_MAX_DEF = 2;
  localparam int PHASE_MARGIN = 2;
  localparam int SYNC_W = 8;
  localparam int SY_REF = 0;
  localparam int SY_TST = 1;
  localparam int SY_SHF = 2;
  localparam int SY_SRQ = 3;
  localparam int SY_WSD = 4;
  localparam int SY_RST = 5;
  localparam int SY_RLO = 6;
  localparam int SY_RHI = 7;
endpackage : rxpa_pkg

/* rtl/rxpa_rate_div.sv */
// Purpose: Word-rate clock divider with full, half and quarter rate
// Assumes: step is a one-cycle enable (every cycle, or test clock edges)
// Notes: word_rise marks new internal bits, word_fall the output launch
`timescale 1ns/1ps
module rxpa_rate_div
  import rxpa_pkg::*;
#(
  parameter int BASE_DIV = BASE_DIV_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic step,
  input wire logic [1:0] rate_sel,
  output logic word_clk,
  output logic word_rise,
  output logic word_fall
);
  localparam int CW = 8;
  logic [CW-1:0] cnt_reg;
  logic [CW-1:0] lim;
  logic [CW-1:0] half;
  // Wrap at or past the last count, so a switch to a faster rate mid-word cannot run the count the long way round
  wire wrap = (cnt_reg >= lim - 8'h01);
  // Longer period for slower rates; test mode keeps full ratio on test edges
  assign lim = (rate_sel == RATE_HALF) ? CW'(BASE_DIV * 2) :
               (rate_sel == RATE_QUARTER) ? CW'(BASE_DIV * 4) : CW'(BASE_DIV);
  assign half = lim >> 1;
  assign word_rise = step & wrap;
  assign word_fall = step & (cnt_reg == half - 8'h01);
  // Counter and clock level; clock high in the first half of the word
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      cnt_reg <= '0;
      word_clk <= 1'b1;
    end else if (step) begin
      cnt_reg <= wrap ? '0 : cnt_reg + 8'h01;
      word_clk <= wrap | (cnt_reg + 8'h01 < half);
    end
  end
endmodule : rxpa_rate_div

/* rtl/rxpa_rx_align.sv */
// Purpose: Receiver output timing, reference-clock retiming and shift chain
// Assumes: rx_code comes from pclk-domain deserialiser logic
// Notes: All eight control and clock pins pass a two-flop synchroniser; rx_code and the APB signals do not
//
// Local design decisions: register access over APB and the register addresses.
`timescale 1ns/1ps
// How it works
// - In reference-clock mode all word and status outputs launch on a reference clock rising edge.
// - Otherwise the same outputs launch on the falling edge of the recovered word clock.
// - The second recovered word clock output is always the inverse of the first.
// - The two rate select pins choose full, half or quarter word rate.
// - With both rate select pins high the word timing steps on the external test clock.
// - The slip output is raised when the delay selection wraps and one word is slipped.
// - In reference-clock mode the shift input picks the delay applied before launch.
// - The shift output comes from the phase between reference edge and internal bits.
// - The shift request output is high when the request input is high or own phase needs a shift.
// - While the alignment reset pin is low word alignment is held reset and restarts on release.
// - While resync disable is high, code-field errors never cause a boundary resync.
// - Ready rises after 64 good words in a row and falls after 2 bad words in a row.
module rxpa_rx_align
  import rxpa_pkg::*;
#(
  parameter int BASE_DIV = BASE_DIV_DEF,
  parameter int GOOD_MIN = GOOD_MIN_DEF,
  parameter int BAD_MAX = BAD_MAX_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic [ADDR_W-1:0] paddr,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic [CODE_W-1:0] rx_code,
  input wire logic local_ref_clock,
  input wire logic ext_serial_test_clock,
  input wire logic rate_select_lo,
  input wire logic rate_select_hi,
  input wire logic shift_delay_in,
  input wire logic shift_request_in,
  input wire logic word_resync_disable,
  input wire logic align_resetn,
  output logic recovered_word_clk,
  output logic recovered_word_clk_n,
  output logic [DATA_W-1:0] data_word_out,
  output logic flag_bit_out,
  output logic data_word_ind,
  output logic control_word_ind,
  output logic word_error_out,
  output logic link_ready_out,
  output logic word_slip_out,
  output logic shift_delay_out,
  output logic shift_request_out,
  output logic word_boundary_slip_req
);
  // ************************************************************
  // Pin synchronisers
  // ************************************************************
  logic [SYNC_W-1:0] pin_raw;
  logic [SYNC_W-1:0] sy1_reg;
  logic [SYNC_W-1:0] sy2_reg;
  logic ref_d_reg;
  logic tst_d_reg;
  assign pin_raw[SY_REF] = local_ref_clock;
  assign pin_raw[SY_TST] = ext_serial_test_clock;
  assign pin_raw[SY_SHF] = shift_delay_in;
  assign pin_raw[SY_SRQ] = shift_request_in;
  assign pin_raw[SY_WSD] = word_resync_disable;
  assign pin_raw[SY_RST] = align_resetn;
  assign pin_raw[SY_RLO] = rate_select_lo;
  assign pin_raw[SY_RHI] = rate_select_hi;
  // Two flops per pin; only the second flop feeds logic
  for (genvar i = 0; i < SYNC_W; i++) begin : g_sync
    always_ff @(posedge pclk or negedge presetn) begin
      if (!presetn) begin
        sy1_reg[i] <= 1'b0;
        sy2_reg[i] <= 1'b0;
      end else begin
        sy1_reg[i] <= pin_raw[i];
        sy2_reg[i] <= sy1_reg[i];
      end
    end
  end
  // Third flop gives edge detection on the two pin clocks
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ref_d_reg <= 1'b0;
      tst_d_reg <= 1'b0;
    end else begin
      ref_d_reg <= sy2_reg[SY_REF];
      tst_d_reg <= sy2_reg[SY_TST];
    end
  end
  wire ref_rise = sy2_reg[SY_REF] & ~ref_d_reg;
  wire tst_rise = sy2_reg[SY_TST] & ~tst_d_reg;
  wire shift_sel = sy2_reg[SY_SHF];
  wire srq_in = sy2_reg[SY_SRQ];
  wire resync_dis = sy2_reg[SY_WSD];
  wire align_rstn = sy2_reg[SY_RST];
  wire [1:0] rate_q = {sy2_reg[SY_RHI], sy2_reg[SY_RLO]};
  // ************************************************************
  // Word-rate timing
  // ************************************************************
  logic word_clk;
  logic word_rise;
  logic word_fall;
  wire test_mode = (rate_q == RATE_TEST);
  wire div_step = test_mode ? tst_rise : 1'b1;
  rxpa_rate_div #(
    .BASE_DIV(BASE_DIV)
  ) u_div (
    .pclk(pclk),
    .presetn(presetn),
    .step(div_step),
    .rate_sel(rate_q),
    .word_clk(word_clk),
    .word_rise(word_rise),
    .word_fall(word_fall)
  );
  // ************************************************************
  // Word decode
  // ************************************************************
  wire [DATA_W-1:0] wf = rx_code[CODE_W-1:WF_LSB];
  wire [3:0] cf = rx_code[WF_LSB-1:0];
  wire [1:0] w78 = {rx_code[W7_POS], rx_code[W8_POS]};
  wire is_dt = (cf == CF_DT0) | (cf == CF_DT1);
  wire is_di = (cf == CF_DI0) | (cf == CF_DI1);
  wire is_d = is_dt | is_di;
  wire flag_dec = (cf == CF_DT1) | (cf == CF_DI1);
  wire is_ct = (cf == CF_CT) & (w78 == W78_CT);
  wire is_ci = (cf == CF_CI) & (w78 == W78_CI);
  wire is_idle = (cf == CF_CT) & ((w78 == W78_IA) | (w78 == W78_IB));
  wire is_c = is_ct | is_ci;
  wire err_dec = ~(is_d | is_c | is_idle);
  wire [DATA_W-3:0] ctl_raw = {wf[15:9], wf[6:0]};
  wire [DATA_W-3:0] ctl_val = is_ci ? ~ctl_raw : ctl_raw;
  wire [DATA_W-1:0] dat_val = is_di ? ~wf : wf;
  wire [DATA_W-1:0] word_val = is_d ? dat_val : (is_c ? {2'h0, ctl_val} : '0);
  wire [BND_W-1:0] bnd_dec = {err_dec, is_c, is_d, flag_dec & is_d, word_val};
  // ************************************************************
  // Word lock
  // ************************************************************
  logic ready_int;
  logic resync_int;
  logic [7:0] good_cnt;
  rxpa_word_lock #(
    .GOOD_MIN(GOOD_MIN),
    .BAD_MAX(BAD_MAX)
  ) u_lock (
    .pclk(pclk),
    .presetn(presetn),
    .align_rstn(align_rstn),
    .resync_dis(resync_dis),
    .word_valid(word_rise),
    .word_err(err_dec),
    .ready(ready_int),
    .resync(resync_int),
    .good_cnt(good_cnt)
  );
  // ************************************************************
  // Delay stages, phase and shift chain
  // ************************************************************
  logic mode_reg;
  logic [BND_W-1:0] st0_reg;
  logic [BND_W-1:0] st1_reg;
  logic [PH_W-1:0] phase_cnt;
  logic [PH_W-1:0] phase_reg;
  logic need_reg;
  logic shift_d_reg;
  logic slip_pend;
  logic fall_d_reg;
  wire launch = mode_reg ? ref_rise : fall_d_reg;
  wire [BND_W-1:0] sel_bnd = shift_sel ? st1_reg : st0_reg;
  wire [BND_W-1:0] out_bnd = mode_reg ? sel_bnd : st0_reg;
  wire phase_short = phase_cnt < PH_W'(PHASE_MARGIN);
  wire shift_chg = mode_reg & (shift_sel != shift_d_reg);
  // Stage 0 holds the newest word, stage 1 the word before it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      st0_reg <= '0;
      st1_reg <= '0;
    end else if (word_rise) begin
      st0_reg <= bnd_dec;
      st1_reg <= st0_reg;
    end
  end
  // Cycles since internal bits changed; saturates so slow rates never wrap
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_cnt <= '0;
    end else if (word_rise) begin
      phase_cnt <= '0;
    end else if (phase_cnt != '1) begin
      phase_cnt <= phase_cnt + 8'h01;
    end
  end
  // Reference edge too close to a bit change flips the delay choice
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      phase_reg <= '0;
      need_reg <= 1'b0;
      shift_delay_out <= 1'b0;
    end else if (ref_rise && mode_reg) begin
      phase_reg <= phase_cnt;
      need_reg <= phase_short;
      shift_delay_out <= shift_delay_out ^ phase_short;
    end
  end
  // Request chain passes upstream requests or asks for its own shift
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_request_out <= 1'b0;
      shift_d_reg <= 1'b0;
      slip_pend <= 1'b0;
      fall_d_reg <= 1'b0;
    end else begin
      fall_d_reg <= word_fall; // Clock pin lags the divider by one flop
      shift_request_out <= srq_in | need_reg;
      shift_d_reg <= shift_sel;
      slip_pend <= shift_chg | (slip_pend & ~launch);
    end
  end
  // ************************************************************
  // Output launch
  // ************************************************************
  // One launch edge for the whole bundle keeps word and status aligned
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      {word_error_out, control_word_ind, data_word_ind, flag_bit_out, data_word_out} <= '0;
      link_ready_out <= 1'b0;
      word_slip_out <= 1'b0;
    end else if (launch) begin
      {word_error_out, control_word_ind, data_word_ind, flag_bit_out, data_word_out} <= out_bnd;
      link_ready_out <= ready_int;
      word_slip_out <= slip_pend;
    end
  end
  // Clock pins and the boundary resync request
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      recovered_word_clk <= 1'b1;
      recovered_word_clk_n <= 1'b0;
      word_boundary_slip_req <= 1'b0;
    end else begin
      recovered_word_clk <= word_clk;
      recovered_word_clk_n <= ~word_clk;
      word_boundary_slip_req <= resync_int;
    end
  end
  // ************************************************************
  // APB slave
  // ************************************************************
  wire apb_setup = psel & ~penable;
  wire apb_wr = psel & penable & pready & pwrite & ~pslverr;
  wire hit_ctrl = (paddr == ADDR_CTRL);
  wire hit_stat = (paddr == ADDR_STAT);
  wire hit_phase = (paddr == ADDR_PHASE);
  wire hit = hit_ctrl | hit_stat | hit_phase;
  wire [3:0] stat_bits = {slip_pend, shift_request_out, need_reg, ready_int};
  wire [31:0] rd_mux = hit_ctrl ? {31'h0000_0000, mode_reg} :
                       hit_stat ? {28'h000_0000, stat_bits} :
                       hit_phase ? {24'h00_0000, phase_reg} : 32'h0000_0000;
  // Answer is prepared in the setup cycle so access needs no wait
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready <= 1'b0;
      pslverr <= 1'b0;
      prdata <= 32'h0000_0000;
    end else begin
      pready <= apb_setup;
      pslverr <= apb_setup & ~hit;
      prdata <= apb_setup ? rd_mux : prdata;
    end
  end
  // Mode bit; change only with the link idle, else one bundle may glitch
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      mode_reg <= CTRL_MODE_RST;
    end else if (apb_wr && hit_ctrl) begin
      mode_reg <= pwdata[CTRL_MODE_BIT];
    end
  end
  // ************************************************************
  // Assertions
  // ************************************************************
  default clocking cb @(posedge pclk); endclocking
  default disable iff (!presetn);
  sequence s_shift_move;
    mode_reg && shift_chg;
  endsequence
  sequence s_slip_out;
    ##[1:40] word_slip_out;
  endsequence
  ref_launch_a: assert property (mode_reg && !ref_rise |=> $stable(data_word_out))
    else $error("data moved without a reference edge");
  fall_launch_a: assert property (!mode_reg && launch |=> data_word_out == $past(st0_reg[DATA_W-1:0]))
    else $error("falling-edge launch lost the word");
  clk_pair_a: assert property (recovered_word_clk_n == !recovered_word_clk)
    else $error("word clocks not complementary");
  rate_ratio_a: assert property (rate_q == RATE_HALF && word_rise && $stable(rate_q)[*2]
    |-> !$past(word_rise, BASE_DIV))
    else $error("half rate period wrong");
  test_step_a: assert property (test_mode && !tst_rise |-> ##2 $stable(recovered_word_clk))
    else $error("word clock moved without a test edge");
  slip_seen_a: assert property (s_shift_move |-> s_slip_out)
    else $error("delay wrap gave no slip");
  shift_phase_a: assert property (mode_reg && ref_rise |=>
    shift_delay_out == ($past(shift_delay_out) ^ ($past(phase_cnt) < PH_W'(PHASE_MARGIN))))
    else $error("shift output not tied to phase");
  srq_pass_a: assert property (srq_in |=> shift_request_out)
    else $error("request not passed on");
  align_hold_a: assert property (!align_rstn ##1 !align_rstn |-> !ready_int)
    else $error("ready while alignment reset");
  no_resync_a: assert property (resync_dis && $past(resync_dis) |-> !resync_int)
    else $error("resync while disabled");
  ready_rise_a: assert property ($rose(ready_int) |-> $past(good_cnt) == 8'(GOOD_MIN - 1))
    else $error("ready rose at wrong count");
endmodule : rxpa_rx_align

/* rtl/rxpa_word_lock.sv */
// Purpose: Word lock tracking, receiver ready and boundary resync request
// Assumes: word_valid pulses once per word with its error flag
// Notes: align_rstn is a synchronised level that acts as a clocked reset
`timescale 1ns/1ps
module rxpa_word_lock
  import rxpa_pkg::*;
#(
  parameter int GOOD_MIN = GOOD_MIN_DEF,
  parameter int BAD_MAX = BAD_MAX_DEF
) (
  input wire logic pclk,
  input wire logic presetn,
  input wire logic align_rstn,
  input wire logic resync_dis,
  input wire logic word_valid,
  input wire logic word_err,
  output logic ready,
  output logic resync,
  output logic [7:0] good_cnt
);
  logic [1:0] bad_reg;
  // Good words build up ready; a run of bad ones drops it
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      good_cnt <= '0;
      bad_reg <= '0;
      ready <= 1'b0;
      resync <= 1'b0;
    end else if (!align_rstn) begin
      good_cnt <= '0;
      bad_reg <= '0;
      ready <= 1'b0;
      resync <= 1'b0;
    end else if (word_valid && word_err) begin
      good_cnt <= '0;
      resync <= 1'b0;
      if (bad_reg == 2'(BAD_MAX - 1)) begin
        ready <= 1'b0;
        bad_reg <= '0;
        resync <= !resync_dis;
      end else begin
        bad_reg <= bad_reg + 2'h1;
      end
    end else if (word_valid) begin
      bad_reg <= '0;
      resync <= 1'b0;
      if (good_cnt == 8'(GOOD_MIN - 1)) begin
        ready <= 1'b1;
      end else if (!ready) begin
        good_cnt <= good_cnt + 8'h01;
      end
    end else begin
      resync <= 1'b0;
    end
  end
endmodule : rxpa_word_lock

/* tb/rx_output_phase_align_tb_top.sv */
// Purpose: Self-checking bench for the receiver output timing block
// Assumes: GOOD_MIN shortened to 4 words; the bus task waits up to 20 cycles for pready
// Notes: The monitor samples at rising edges, so it sees settled values
`timescale 1ns/1ps
module rx_output_phase_align_tb_top;
  import rxpa_pkg::*;
  localparam int GM = 4;
  localparam logic [19:0] CODES [7] = '{{16'hA5C3, CF_DT0}, {~16'h1234, CF_DI0}, {16'h0F0F, CF_DT1},
    {~16'h8001, CF_DI1}, {7'h55, 2'h2, 7'h3C, CF_CT}, {7'h2A, 2'h1, 7'h43, CF_CI}, {16'h0000, 4'h9}};
  localparam logic [19:0] EXPS [7] = '{{16'hA5C3, 4'h4}, {16'h1234, 4'h4}, {16'h0F0F, 4'hC},
    {16'h8001, 4'hC}, {16'h2ABC, 4'h2}, {16'h2ABC, 4'h2}, {16'h0000, 4'h1}};
  logic pclk, presetn, psel, penable, pwrite, pready, pslverr, e, mode, mon, pw, pref, m_en, m_shf, tst_run;
  logic [ADDR_W-1:0] paddr;
  logic [31:0] pwdata, prdata, q;
  logic [CODE_W-1:0] rx_code;
  logic local_ref_clock, ext_serial_test_clock, rate_select_lo, rate_select_hi, shift_delay_in;
  logic shift_request_in, word_resync_disable, align_resetn, recovered_word_clk, recovered_word_clk_n;
  logic flag_bit_out, data_word_ind, control_word_ind, word_error_out, link_ready_out, word_slip_out;
  logic shift_delay_out, shift_request_out, word_boundary_slip_req;
  logic [DATA_W-1:0] data_word_out, pd;
  logic [15:0] slip_seen, s;
  int err_count, total_checks, nfall, nbs, age, t, c;
  rxpa_rx_align #(.BASE_DIV(BASE_DIV_DEF), .GOOD_MIN(GM), .BAD_MAX(BAD_MAX_DEF)) u_dut (
    .pclk, .presetn, .paddr, .psel, .penable, .pwrite, .pwdata, .prdata, .pready, .pslverr,
    .rx_code, .local_ref_clock, .ext_serial_test_clock, .rate_select_lo, .rate_select_hi,
    .shift_delay_in, .shift_request_in, .word_resync_disable, .align_resetn, .recovered_word_clk,
    .recovered_word_clk_n, .data_word_out, .flag_bit_out, .data_word_ind, .control_word_ind,
    .word_error_out, .link_ready_out, .word_slip_out, .shift_delay_out, .shift_request_out,
    .word_boundary_slip_req);
  rxpa_user_model u_user (.pclk, .presetn, .shift_delay_out, .word_slip_out,
    .ext_master_en(m_en), .ext_master_shift(m_shf), .shift_delay_in, .slip_seen);
  // ************************************************************
  // Clocks, checks and bus tasks
  // ************************************************************
  initial begin
    pclk = 1'b0;
    forever #25 pclk = ~pclk;
  end
  // Reference runs free at the link rate; test clock only on demand
  always #200 local_ref_clock = ~local_ref_clock;
  always #100 if (tst_run) ext_serial_test_clock = ~ext_serial_test_clock;
  task automatic chkb(input string nm, input logic x, input logic g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %b seen %b", nm, x, g);
    end
  endtask : chkb
  task automatic chkw(input string nm, input logic [31:0] x, input logic [31:0] g);
    total_checks++;
    if (g !== x) begin
      err_count++;
      $display("[FAIL] %s expected %h seen %h", nm, x, g);
    end
  endtask : chkw
  task automatic test_done;
    $display("Checks %0d mismatches %0d", total_checks, err_count);
    if (err_count == 0 && total_checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : test_done
  // Waits for n word clock falls; a stalled clock ends the run
  task automatic wfall(input int n);
    int k;
    k = nfall + n;
    for (int i = 0; i < 200 * n && nfall < k; i++) begin
      @(posedge pclk);
    end
    if (nfall < k) begin
      chkb("word clock timeout", 1'b1, 1'b0);
      test_done();
    end
  endtask : wfall
  // New code just after a fall, so the next fall launches it once
  task automatic put(input logic [19:0] cd);
    wfall(1);
    rx_code <= cd;
  endtask : put
  // Request held until pready is seen high at a rising edge
  task automatic apb(input logic [7:0] a, input logic w, input logic [31:0] d);
    int i;
    @(posedge pclk);
    paddr <= a;
    pwrite <= w;
    pwdata <= d;
    psel <= 1'b1;
    @(posedge pclk);
    penable <= 1'b1;
    i = 0;
    do begin
      @(posedge pclk);
      i++;
    end while (pready !== 1'b1 && i < 20);
    if (pready !== 1'b1) begin
      chkb("pready timeout", 1'b1, 1'b0);
      test_done();
    end
    q = prdata;
    e = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  // Launch timing watch, using values sampled before the edge
  always @(posedge pclk) begin
    pw <= recovered_word_clk;
    pd <= data_word_out;
    pref <= local_ref_clock;
    age <= (local_ref_clock && !pref) ? 0 : age + 1;
    if (pw === 1'b1 && recovered_word_clk === 1'b0) nfall <= nfall + 1;
    if (word_boundary_slip_req === 1'b1) nbs <= nbs + 1;
    if (mon) begin
      chkb("word clock pair", ~recovered_word_clk, recovered_word_clk_n);
      if (data_word_out !== pd && mode) chkb("launch near ref rise", 1'b1, age >= 1 && age <= 6);
      if (data_word_out !== pd && !mode) chkb("launch on fall", 1'b1, pw && !recovered_word_clk);
    end
  end
  // ************************************************************
  // Test sequence
  // ************************************************************
  initial begin
    {presetn, psel, penable, pwrite, mode, mon, pw, pref, m_en, m_shf, tst_run} = '0;
    {local_ref_clock, ext_serial_test_clock, rate_select_lo, rate_select_hi} = '0;
    {shift_request_in, word_resync_disable, paddr, pwdata, rx_code} = '0;
    {err_count, total_checks, nfall, nbs, age} = '0;
    align_resetn = 1'b1;
    repeat (10) @(posedge pclk);
    chkb("reset word clock", 1'b1, recovered_word_clk);
    presetn <= 1'b1;
    mon = 1'b1;
    apb(ADDR_CTRL, 1'b0, 32'h0000_0000);
    chkw("control reset", {31'h0000_0000, CTRL_MODE_RST}, q);
    apb(8'h0C, 1'b1, 32'h0000_0001);
    chkb("unmapped error", 1'b1, e);
    $display("Test registers done");
    put(CODES[0]);
    wfall(1);
    chkb("ready early", 1'b0, link_ready_out);
    wfall(GM + 2);
    chkb("ready after good run", 1'b1, link_ready_out);
    for (int i = 0; i < 7; i++) begin
      put(CODES[i]);
      wfall(1);
      chkw("word outputs", {12'h000, EXPS[i]}, {12'h000, data_word_out, flag_bit_out, data_word_ind,
        control_word_ind, word_error_out});
    end
    chkb("ready after one bad", 1'b1, link_ready_out);
    t = nbs;
    wfall(2);
    chkb("ready after two bad", 1'b0, link_ready_out);
    chkb("resync pulse", 1'b1, nbs > t);
    @(posedge pclk);
    word_resync_disable <= 1'b1;
    wfall(2);
    t = nbs;
    wfall(6);
    chkb("resync held off", 1'b1, nbs == t);
    word_resync_disable <= 1'b0;
    $display("Test words and ready done");
    put(CODES[0]);
    wfall(GM + 2);
    align_resetn <= 1'b0;
    wfall(GM + 2);
    chkb("ready in align reset", 1'b0, link_ready_out);
    align_resetn <= 1'b1;
    wfall(GM + 3);
    chkb("ready after release", 1'b1, link_ready_out);
    $display("Test align reset done");
    for (int r = 0; r < 3; r++) begin
      @(posedge pclk);
      {rate_select_hi, rate_select_lo} <= 2'(r);
      wfall(3);
      t = nfall;
      c = 0;
      while (nfall == t && c < 300) begin
        @(negedge pclk);
        c++;
      end
      chkw("word period", 32'(BASE_DIV_DEF << r), 32'(c));
    end
    {rate_select_hi, rate_select_lo} <= 2'h3;
    repeat (8) @(posedge pclk);
    t = nfall;
    repeat (80) @(posedge pclk);
    chkb("held without test clock", 1'b1, nfall == t);
    tst_run = 1'b1;
    repeat (300) @(posedge pclk);
    chkb("steps on test clock", 1'b1, nfall > t);
    tst_run = 1'b0;
    {rate_select_hi, rate_select_lo} <= 2'h0;
    wfall(2);
    $display("Test rates done");
    mon = 1'b0;
    apb(ADDR_CTRL, 1'b1, 32'h0000_0001);
    mode = 1'b1;
    repeat (40) @(posedge pclk);
    mon = 1'b1;
    for (int i = 0; i < 4; i++) begin
      put(CODES[i]);
      repeat (20) @(posedge pclk);
    end
    apb(ADDR_PHASE, 1'b0, 32'h0000_0000);
    c = int'(q[7:0]);
    apb(ADDR_STAT, 1'b0, 32'h0000_0000);
    chkb("shift need", c < PHASE_MARGIN, q[STAT_NEED_BIT]);
    chkb("request from need", q[STAT_NEED_BIT], shift_request_out);
    shift_request_in <= 1'b1;
    repeat (5) @(posedge pclk);
    chkb("request passed on", 1'b1, shift_request_out);
    shift_request_in <= 1'b0;
    s = slip_seen;
    m_en <= 1'b1;
    m_shf <= ~shift_delay_in;
    repeat (60) @(posedge pclk);
    chkb("slip on delay change", 1'b1, slip_seen != s);
    m_en <= 1'b0;
    $display("Test reference mode done");
    test_done();
  end
endmodule : rx_output_phase_align_tb_top

/* tb/rxpa_user_model.sv */
// Purpose: User side of one receiver: closes the shift loop and watches slips
// Assumes: A lone receiver unless ext_master_en selects a master's shift line
// Notes: slip_seen counts clock cycles with the slip output high
`timescale 1ns/1ps
module rxpa_user_model
  import rxpa_pkg::*;
(
  input wire logic pclk,
  input wire logic presetn,
  input wire logic shift_delay_out,
  input wire logic word_slip_out,
  input wire logic ext_master_en,
  input wire logic ext_master_shift,
  output logic shift_delay_in,
  output logic [15:0] slip_seen
);
  // ************************************************************
  // Shift wiring and slip count
  // ************************************************************
  // Loop back our own shift, or take the master's in a chain
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      shift_delay_in <= 1'b0;
      slip_seen <= 16'h0000;
    end else begin
      shift_delay_in <= ext_master_en ? ext_master_shift : shift_delay_out;
      slip_seen <= slip_seen + {15'h0000, word_slip_out};
    end
  end
endmodule : rxpa_user_model
